//--- src/dsw_top.sv
// Top of the serial write and power mode front end
//
// Notes on behaviour
// - Reset clears code to zero, normal mode
// - Frame bits 17:16 select the operating mode
// - Power-down picks 1k, 100k or open output
// - Any power-down mode turns analog enable off
// - Frames in power-down still load the stored code
// - Output valid only after settle time on wake
// - Frames shift into a 23-bit register; bit 24 goes straight to the hold word
// - Top six frame bits are ignored
// - Low 16 bits load code on 24th edge
// - Narrow variant uses upper twelve data bits
// - A frame starts only after select falls
// - Data sampled on each of the first 24 serial clock falls of a frame
// - 24th falling edge executes the frame
// - Early select rise discards the frame
// - Code is straight unsigned binary
// - First bit received is frame bit 23
`timescale 1ns/10ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_top #(
  parameter int RES_BITS = `DSW_RES_BITS,
  parameter logic [11:0] SETTLE_CYC = 12'(`DSW_SETTLE_CYC)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serClk,
  input wire logic frameSelN,
  input wire logic serData,
  output logic [15:0] dacCode,
  output logic [1:0] powerMode,
  output logic ampEnable,
  output logic outTerm1k,
  output logic outTerm100k,
  output logic outHighZ,
  output logic outputValid,
  output logic frameLoaded
);

  dsw_pkg::dsw_top_type st_r;
  dsw_pkg::dsw_top_type st_nxt;
  logic [17:0] frameWord;
  logic frameTgl;
  logic settleDone;
  logic commit;
  dsw_pkg::dsw_mode_type newMode;
  logic [15:0] newCode;

  // Narrow variant: the low data bits beyond the resolution are dropped
  function automatic logic [15:0] dsw_mask_code(input logic [15:0] d);
    logic [15:0] m;
    m = 16'hFFFF << (`DSW_CODE_W - RES_BITS);
    return d & m;
  endfunction

  dsw_link_rx u_link (
    .serClk(serClk),
    .frameSelN(frameSelN),
    .serData(serData),
    .srst(srst),
    .frameWord(frameWord),
    .frameTgl(frameTgl)
  );

  dsw_settle_timer #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_settle (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(st_r.settleStart),
    .done(settleDone)
  );

  // A toggle edge seen past the second stage marks one executed frame
  assign commit = st_r.tgS2 ^ st_r.tgS3;
  assign newMode = dsw_pkg::dsw_mode_type'(frameWord[`DSW_MODE_HI:`DSW_MODE_LO]);
  assign newCode = dsw_mask_code(frameWord[`DSW_DATA_HI:`DSW_DATA_LO]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.tgS1 = frameTgl;
    st_nxt.tgS2 = st_r.tgS1;
    st_nxt.tgS3 = st_r.tgS2;
    st_nxt.settleStart = 1'b0;
    if (commit) begin
      // The code loads even in power-down; only the output stage is off
      st_nxt.code = newCode;
      st_nxt.mode = newMode;
      st_nxt.loaded = 1'b1;
    end
    case (st_r.pwr)
      dsw_pkg::DSW_PWR_ACTIVE: begin
        if (commit && newMode != dsw_pkg::DSW_MODE_NORMAL) begin
          st_nxt.pwr = dsw_pkg::DSW_PWR_DOWN;
        end
      end
      dsw_pkg::DSW_PWR_DOWN: begin
        if (commit && newMode == dsw_pkg::DSW_MODE_NORMAL) begin
          st_nxt.pwr = dsw_pkg::DSW_PWR_WAKE;
          st_nxt.settleStart = 1'b1;
        end
      end
      dsw_pkg::DSW_PWR_WAKE: begin
        if (commit && newMode != dsw_pkg::DSW_MODE_NORMAL) begin
          st_nxt.pwr = dsw_pkg::DSW_PWR_DOWN;
        end else if (settleDone) begin
          st_nxt.pwr = dsw_pkg::DSW_PWR_ACTIVE;
        end
      end
      default: begin
        st_nxt.pwr = dsw_pkg::DSW_PWR_ACTIVE;
      end
    endcase
    st_nxt.ampEn = (st_nxt.mode == dsw_pkg::DSW_MODE_NORMAL);
    st_nxt.term1k = (st_nxt.mode == dsw_pkg::DSW_MODE_PD1K);
    st_nxt.term100k = (st_nxt.mode == dsw_pkg::DSW_MODE_PD100K);
    st_nxt.hiZ = (st_nxt.mode == dsw_pkg::DSW_MODE_HIZ);
    st_nxt.outValid = (st_nxt.pwr == dsw_pkg::DSW_PWR_ACTIVE);
  end

  // Power-on state drives zero code with the amplifier on
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.ampEn <= 1'b1;
      st_r.outValid <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dacCode = st_r.code;
  assign powerMode = st_r.mode;
  assign ampEnable = st_r.ampEn;
  assign outTerm1k = st_r.term1k;
  assign outTerm100k = st_r.term100k;
  assign outHighZ = st_r.hiZ;
  assign outputValid = st_r.outValid;
  assign frameLoaded = st_r.loaded;

  // Window follows the instance's own settle count, not the default
  localparam int SettleLo = int'(SETTLE_CYC) - 1;
  localparam int SettleHi = int'(SETTLE_CYC) + 4;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence seq_frame_seen;
    commit;
  endsequence

  sequence seq_frame_applied;
    ##1 st_r.loaded && st_r.mode == $past(newMode);
  endsequence

  sequence seq_wake_begin;
    $rose(st_r.ampEn);
  endsequence

  sequence seq_wake_req;
    commit && newMode == dsw_pkg::DSW_MODE_NORMAL && st_r.pwr == dsw_pkg::DSW_PWR_DOWN;
  endsequence

  property p_reset_zero;
    $past(srst) |-> (st_r.code == `DSW_CODE_RST && st_r.mode == `DSW_MODE_RST && st_r.ampEn);
  endproperty

  property p_commit_mode;
    seq_frame_seen |-> seq_frame_applied;
  endproperty

  property p_commit_code;
    commit |=> st_r.code == $past(newCode);
  endproperty

  property p_no_frame_hold;
    !commit |=> $stable(st_r.code) && $stable(st_r.mode);
  endproperty

  property p_pd_outputs;
    st_r.mode != dsw_pkg::DSW_MODE_NORMAL |-> !st_r.ampEn && !st_r.outValid;
  endproperty

  property p_term_select;
    (st_r.term1k == (st_r.mode == dsw_pkg::DSW_MODE_PD1K))
      && (st_r.term100k == (st_r.mode == dsw_pkg::DSW_MODE_PD100K))
      && (st_r.hiZ == (st_r.mode == dsw_pkg::DSW_MODE_HIZ));
  endproperty

  property p_wake_hold;
    seq_wake_begin |-> (!st_r.outValid)[*8];
  endproperty

  property p_wake_end;
    seq_wake_begin |-> ##[SettleLo:SettleHi] (st_r.outValid || !st_r.ampEn);
  endproperty

  property p_toggle_commit;
    commit |=> !commit;
  endproperty

  property p_narrow_code;
    st_r.code == dsw_mask_code(st_r.code);
  endproperty

  property p_amp_normal;
    st_r.mode == dsw_pkg::DSW_MODE_NORMAL |-> st_r.ampEn;
  endproperty

  property p_pd_code_hold;
    st_r.pwr == dsw_pkg::DSW_PWR_DOWN && !commit |=> $stable(st_r.code);
  endproperty

  property p_valid_active;
    st_r.outValid == (st_r.pwr == dsw_pkg::DSW_PWR_ACTIVE);
  endproperty

  property p_power_mode;
    st_r.pwr != dsw_pkg::DSW_PWR_DOWN |-> st_r.mode == dsw_pkg::DSW_MODE_NORMAL;
  endproperty

  property p_loaded_sticky;
    st_r.loaded |=> st_r.loaded;
  endproperty

  property p_wake_start;
    seq_wake_req |=> st_r.settleStart && !st_r.outValid && st_r.ampEn;
  endproperty

  property p_pd_enter;
    commit && newMode != dsw_pkg::DSW_MODE_NORMAL |=> st_r.pwr == dsw_pkg::DSW_PWR_DOWN && !st_r.outValid;
  endproperty

  property p_settle_pulse;
    st_r.settleStart |=> !st_r.settleStart;
  endproperty

  property p_reset_state;
    $past(srst) |-> st_r.outValid && !st_r.loaded && st_r.pwr == dsw_pkg::DSW_PWR_ACTIVE;
  endproperty

  a_reset_zero: assert property (p_reset_zero)
    else $error("code or mode not cleared by reset");

  a_mode_update: assert property (p_commit_mode)
    else $error("mode not taken from executed frame");

  a_code_update: assert property (p_commit_code)
    else $error("code not taken from executed frame");

  a_abort_hold: assert property (p_no_frame_hold)
    else $error("code or mode changed without a frame");

  a_pd_amp_off: assert property (p_pd_outputs)
    else $error("analog enable on during power-down");

  a_term_select: assert property (p_term_select)
    else $error("output termination does not match mode");

  a_wake_hold: assert property (p_wake_hold)
    else $error("output valid too early after wake");

  a_wake_end: assert property (p_wake_end)
    else $error("output not valid after settle time");

  a_toggle_commit: assert property (p_toggle_commit)
    else $error("one toggle executed twice");

  a_narrow_code: assert property (p_narrow_code)
    else $error("code bits below resolution not zero");

  a_amp_normal: assert property (p_amp_normal)
    else $error("analog enable off in normal mode");

  a_pd_code_hold: assert property (p_pd_code_hold)
    else $error("code changed while powered down");

  a_valid_active: assert property (p_valid_active)
    else $error("output valid does not match power state");

  a_power_mode: assert property (p_power_mode)
    else $error("power state disagrees with mode");

  a_loaded_sticky: assert property (p_loaded_sticky)
    else $error("loaded flag dropped");

  a_wake_start: assert property (p_wake_start)
    else $error("wake did not start settle timer");

  a_pd_enter: assert property (p_pd_enter)
    else $error("power-down frame did not power down");

  a_settle_pulse: assert property (p_settle_pulse)
    else $error("settle start longer than one cycle");

  a_reset_state: assert property (p_reset_state)
    else $error("power state not active after reset");

endmodule
`default_nettype wire

//--- src/dsw_cfg.svh
// Constants for the serial write and power mode front end
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

`define DSW_FRAME_BITS 24
`define DSW_LAST_BIT 5'd23
`define DSW_CNT_W 5
`define DSW_SHIFT_W 23
`define DSW_HOLD_W 18
`define DSW_MODE_HI 17
`define DSW_MODE_LO 16
`define DSW_DATA_HI 15
`define DSW_DATA_LO 0
`define DSW_CODE_W 16
`define DSW_RES_BITS 16
`define DSW_CODE_RST 16'h0000
`define DSW_MODE_RST 2'h0
`define DSW_CLK_NS 10
`define DSW_SETTLE_NS 2500
`define DSW_SETTLE_CYC ((`DSW_SETTLE_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)
`define DSW_TMR_W 12

`endif

//--- src/dsw_pkg.sv
// Types for the serial write and power mode front end
package dsw_pkg;

  typedef enum logic [1:0] {
    DSW_MODE_NORMAL = 2'h0,
    DSW_MODE_PD1K = 2'h1,
    DSW_MODE_PD100K = 2'h2,
    DSW_MODE_HIZ = 2'h3
  } dsw_mode_type;

  typedef enum logic [1:0] {
    DSW_PWR_ACTIVE = 2'h0,
    DSW_PWR_DOWN = 2'h1,
    DSW_PWR_WAKE = 2'h3
  } dsw_pwr_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic [22:0] shift;
    logic done;
  } dsw_shift_type;

  typedef struct packed {
    logic [17:0] word;
    logic tgl;
  } dsw_hold_type;

  typedef struct packed {
    logic [11:0] cnt;
    logic busy;
    logic done;
  } dsw_tmr_type;

  typedef struct packed {
    logic tgS1;
    logic tgS2;
    logic tgS3;
    logic [15:0] code;
    dsw_mode_type mode;
    dsw_pwr_type pwr;
    logic ampEn;
    logic term1k;
    logic term100k;
    logic hiZ;
    logic outValid;
    logic settleStart;
    logic loaded;
  } dsw_top_type;

endpackage

//--- src/dsw_link_rx.sv
// Serial link receiver running on the falling edge of the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_link_rx (
  input wire logic serClk,
  input wire logic frameSelN,
  input wire logic serData,
  input wire logic srst,
  output logic [17:0] frameWord,
  output logic frameTgl
);

  dsw_pkg::dsw_shift_type sh_r;
  dsw_pkg::dsw_shift_type sh_nxt;
  dsw_pkg::dsw_hold_type hold_r;
  dsw_pkg::dsw_hold_type hold_nxt;

  always_comb begin
    sh_nxt = sh_r;
    hold_nxt = hold_r;
    if (!sh_r.done) begin
      if (sh_r.cnt == `DSW_LAST_BIT) begin
        // Only the low 18 frame bits are kept; the top six are dropped
        hold_nxt.word = {sh_r.shift[16:0], serData};
        hold_nxt.tgl = ~hold_r.tgl;
        sh_nxt.done = 1'b1;
      end else begin
        sh_nxt.shift = {sh_r.shift[21:0], serData};
        sh_nxt.cnt = sh_r.cnt + 5'd1;
      end
    end
  end

  // Frame select high clears the counter: an early rise aborts the frame
  always_ff @(negedge serClk or posedge frameSelN or posedge srst) begin
    if (frameSelN || srst) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  // Held word stays put until the next full frame, long after the crossing
  always_ff @(negedge serClk or posedge srst) begin
    if (srst) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign frameWord = hold_r.word;
  assign frameTgl = hold_r.tgl;

endmodule
`default_nettype wire

//--- src/dsw_settle_timer.sv
// Down counter that reports when the output has settled after wake up
`timescale 1ns/10ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_settle_timer #(
  parameter logic [11:0] SETTLE_CYC = 12'(`DSW_SETTLE_CYC)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  output logic done
);

  dsw_pkg::dsw_tmr_type st_r;
  dsw_pkg::dsw_tmr_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      // A restart drops any count in flight so no stale done escapes
      st_nxt.cnt = SETTLE_CYC;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.cnt <= 12'h001) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule
`default_nettype wire

//--- tb/dsw_host_model.sv
// Host serial master model that drives write frames
`timescale 1ns/10ps
`default_nettype none

module dsw_host_model (
  output logic serClk,
  output logic frameSelN,
  output logic serData
);
  initial begin
    serClk = 1'b1;
    frameSelN = 1'b1;
    serData = 1'b0;
  end

  // Clock idles high and toggles only inside a frame
  task automatic send(input logic [23:0] word, input int nBits);
    int i;
    frameSelN = 1'b0;
    for (i = 0; i < nBits; i++) begin
      serData = (i < 24) ? word[23 - i] : ~serData;
      #62.5 serClk = 1'b0;
      #62.5 serClk = 1'b1;
    end
    // Released data line shows the inverse so a stale bit cannot look valid
    serData = ~serData;
    #20 frameSelN = 1'b1;
    #40;
  endtask
endmodule

`default_nettype wire

//--- tb/test_dsw_top.sv
// Self-checking bench for the serial write and power mode front end
`timescale 1ns/10ps
`default_nettype none

module test_dsw_top;
  // Short settle count keeps the wake check quick
  localparam logic [11:0] SETTLE = 12'h00C;
  // Clock starts high and reset low so the first reset gives the link side a real edge
  logic ref_clk = 1'b1;
  logic srst = 1'b0;
  logic [15:0] narrowCode;
  logic serClk, frameSelN, serData;
  logic [15:0] dacCode;
  logic [1:0] powerMode;
  logic ampEnable, outTerm1k, outTerm100k, outHighZ, outputValid, frameLoaded;
  logic [17:0] noteQ[$];
  logic [17:0] expNote, prevOut, curState;
  logic [15:0] rnd = 16'h001E;
  logic ampPrev, validPrev;
  int error_cnt = 0;
  int n_checks = 0;
  int wakeCnt = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  dsw_host_model host (.serClk(serClk), .frameSelN(frameSelN), .serData(serData));

  dsw_top #(.RES_BITS(16), .SETTLE_CYC(SETTLE)) dut (.ref_clk(ref_clk), .srst(srst), .serClk(serClk),
    .frameSelN(frameSelN), .serData(serData), .dacCode(dacCode), .powerMode(powerMode),
    .ampEnable(ampEnable), .outTerm1k(outTerm1k), .outTerm100k(outTerm100k), .outHighZ(outHighZ),
    .outputValid(outputValid), .frameLoaded(frameLoaded));

  dsw_top #(.RES_BITS(12), .SETTLE_CYC(SETTLE)) dutNarrow (.ref_clk(ref_clk), .srst(srst), .serClk(serClk),
    .frameSelN(frameSelN), .serData(serData), .dacCode(narrowCode), .powerMode(), .ampEnable(), .outTerm1k(),
    .outTerm100k(), .outHighZ(), .outputValid(), .frameLoaded());

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    srst <= 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(32'({dacCode, powerMode}), 32'h0, "reset code and mode");
    chk(32'({ampEnable, outTerm1k, outTerm100k, outHighZ, outputValid, frameLoaded}), 32'h22, "reset flags");
    srst <= 1'b0;
    curState = '0;
    repeat (2) @(negedge ref_clk);
  endtask

  // Notes an expectation only when the outputs must visibly change
  task automatic frame(input logic [1:0] mode, input logic [15:0] code, input int nBits);
    rnd = lfsr(rnd);
    @(negedge ref_clk);
    if (nBits >= 24) begin
      if ({mode, code} !== curState) begin
        noteQ.push_back({mode, code});
      end
      curState = {mode, code};
    end
    host.send({rnd[5:0], mode, code}, nBits);
    repeat (8) @(negedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  always @(posedge ref_clk) begin
    if (srst === 1'b0 && {powerMode, dacCode} !== prevOut) begin
      if (noteQ.size() == 0) begin
        chk(32'h1, 32'h0, "output change with no executed frame");
      end else begin
        expNote = noteQ.pop_front();
        chk(32'(dacCode), 32'(expNote[15:0]), "code");
        chk(32'(powerMode), 32'(expNote[17:16]), "mode");
        chk(32'({ampEnable, outTerm1k, outTerm100k, outHighZ}), 32'({expNote[17:16] == 2'h0,
          expNote[17:16] == 2'h1, expNote[17:16] == 2'h2, expNote[17:16] == 2'h3}), "output stage");
        chk(32'(frameLoaded), 32'h1, "loaded flag");
        chk(32'(narrowCode), 32'(expNote[15:0] & 16'hFFF0), "narrow code");
        if (expNote[17:16] != 2'h0) begin
          chk(32'(outputValid), 32'h0, "valid in power-down");
        end
      end
    end
    if (ampEnable === 1'b1 && ampPrev !== 1'b1) begin
      wakeCnt = 0;
    end else begin
      wakeCnt++;
    end
    if (srst === 1'b0 && outputValid === 1'b1 && validPrev === 1'b0) begin
      chk(32'(wakeCnt >= SETTLE + 1 && wakeCnt <= SETTLE + 2), 32'h1, "settle time");
    end
    prevOut = {powerMode, dacCode};
    ampPrev = ampEnable;
    validPrev = outputValid;
  end

  initial begin
    do_reset();
    $display("test reset done");
    for (int m = 1; m < 5; m++) begin
      frame(2'(m), rnd, 24);
    end
    repeat (30) @(negedge ref_clk);
    chk(32'(outputValid), 32'h1, "valid after wake");
    $display("test modes and wake done");
    frame(2'h0, 16'hFFFF, 23);
    frame(2'h1, 16'h0001, 10);
    frame(2'h0, 16'h8000, 24);
    frame(2'h2, 16'h1234, 30);
    $display("test abort and extra edges done");
    do_reset();
    frame(2'h0, 16'hFFFF, 24);
    repeat (20) @(negedge ref_clk);
    chk(32'(noteQ.size()), 32'h0, "pending updates");
    $display("test second reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
